// ===== adcc_pkg.sv
// package for the converter control and result register block
// assumes an APB3 master on pclk and an analog core fed by adcc_core_req_s
// Contract
// RULE1 - enable powers on, disable aborts conversion
// RULE2 - single mode: each start write converts once
// RULE3 - free running: start write launches first only
// RULE4 - first conversion 25 cycles, later 13
// RULE5 - start bit reads busy, zero write ignored
// RULE6 - auto trigger starts on selected rising edge
// RULE7 - done flag set when result updated
// RULE8 - irq when flag, enable, global enable
// RULE9 - vector ack or written one clears flag
// RULE10 - software avoids read-modify-write of control A
// RULE11 - divider codes 0,1 by 2, then 4..128
// RULE12 - low read locks result until high read
// RULE13 - software reads low byte before high
// RULE14 - right/left alignment byte layout of result
// RULE15 - trigger source ignored without auto trigger
// RULE16 - trigger source code map, rising edge
// RULE17 - switching to set source makes an edge
// RULE18 - selecting free running never triggers
// RULE19 - software writes zero to control B bit7
// RULE20 - input disable bit forces pin read zero
// RULE21 - software disables unused analog pin inputs
// RULE22 - alignment change re-presents result immediately
// RULE23 - reference/channel changes apply after conversion
// RULE24 - unused bits read zero, writes ignored
// RULE25 - free running: each completion triggers next
package adcc_pkg;
   // register indices; byte address is four times the index
   localparam logic [9:0] IDX_RESULT_LOW = 10'h078;
   localparam logic [9:0] IDX_RESULT_HIGH = 10'h079;
   localparam logic [9:0] IDX_CTRL_A = 10'h07A;
   localparam logic [9:0] IDX_CTRL_B = 10'h07B;
   localparam logic [9:0] IDX_CHAN_REF = 10'h07C;
   localparam logic [9:0] IDX_PIN_DISABLE = 10'h07E;
   localparam logic [7:0] REG_RESET = 8'h00;

   // control A fields
   localparam int A_ENABLE = 7;
   localparam int A_START = 6;
   localparam int A_AUTO = 5;
   localparam int A_FLAG = 4;
   localparam int A_IRQ_EN = 3;
   localparam int A_DIV_LSB = 0;
   // control B fields
   localparam int B_CMP_MUX = 6;
   localparam int B_TRIG_LSB = 0;
   // channel/reference register fields
   localparam int C_REF_LSB = 6;
   localparam int C_ALIGN = 5;
   localparam int C_CHAN_LSB = 0;

   // conversion lengths in converter clocks
   localparam logic [4:0] FIRST_CONV_CYCLES = 5'h19;
   localparam logic [4:0] NORMAL_CONV_CYCLES = 5'h0D;
   localparam logic [2:0] TRIG_FREE_RUN = 3'h0;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_CONV = 1'b1
   } adcc_state_e;

   // request bundle toward the analog core
   typedef struct packed {
      logic busy;
      logic start;
      logic first;
      logic tick;
      logic [1:0] reference;
      logic [4:0] channel;
      logic powered;
   } adcc_core_req_s;

   // analog pin digital-input group
   typedef struct packed {
      logic [7:0] buffer_off;
      logic [7:0] value;
   } adcc_pin_out_s;
endpackage

// ===== adcc_top.sv
// control, triggering and result registers around the 10-bit converter
// assumes APB3 master on pclk; core result valid on the last converter tick
`timescale 1ns/1ps
`default_nettype none
module adcc_top (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // analog core
   output adcc_pkg::adcc_core_req_s core_req,
   input wire logic [9:0] core_result,
   // trigger flags, index is trigger source code 1..7
   input wire logic [7:1] trig_flags,
   // interrupt handshake with the processor
   input wire logic global_irq_enable,
   input wire logic irq_vector_ack,
   output logic irq_req,
   // analog pins
   input wire logic [7:0] pin_raw,
   output adcc_pkg::adcc_pin_out_s pins,
   output logic comparator_mux_enable
);
   typedef struct packed {
      adcc_pkg::adcc_state_e st;
      logic en;
      logic ate;
      logic flag;
      logic ie;
      logic [2:0] div;
      logic align;
      logic [1:0] refsel;
      logic [4:0] chsel;
      logic cme;
      logic [2:0] ts;
      logic [7:0] didr;
      logic [9:0] result;
      logic lock;
      logic init_pend;
      logic [4:0] cyc;
      logic [6:0] pre;
      logic trig_prev;
      logic [1:0] conv_ref;
      logic [4:0] conv_ch;
      logic conv_first;
      logic start_p;
      logic [7:0] rdata;
      logic [7:0] pin_val;
   } adcc_reg_s;

   adcc_reg_s s_q;
   adcc_reg_s s_d;

   logic [9:0] idx;
   logic setup;
   logic access;
   logic wr;
   logic rd;
   logic mapped;
   logic [7:0] wb;
   logic [6:0] div_m1;
   logic tick;
   logic done;
   logic trig_sel;
   logic trig_edge;
   logic sw_start;
   logic start;
   logic [7:0] ctrl_a_rd;
   logic [7:0] low_rd;
   logic [7:0] high_rd;
   logic [7:0] rd_mux;
   logic low_hold;

   // apb decode; zero wait states, read data captured in setup
   assign idx = paddr[11:2];
   assign setup = psel & ~penable;
   assign access = psel & penable;
   assign wr = access & pwrite & mapped;
   assign rd = access & ~pwrite & mapped;
   assign wb = pwdata[7:0];
   assign pready = 1'b1;
   assign pslverr = access & ~mapped;
   always_comb begin
      mapped = (paddr[1:0] == 2'h0);
      case (idx)
         adcc_pkg::IDX_RESULT_LOW,
         adcc_pkg::IDX_RESULT_HIGH,
         adcc_pkg::IDX_CTRL_A,
         adcc_pkg::IDX_CTRL_B,
         adcc_pkg::IDX_CHAN_REF,
         adcc_pkg::IDX_PIN_DISABLE: mapped = mapped & 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // prescaler: codes 0 and 1 both give divide by 2
   always_comb begin
      if (s_q.div < 3'h2) begin
         div_m1 = 7'h01; // RULE11
      end else begin
         div_m1 = 7'((8'h01 << s_q.div) - 8'h01); // RULE11
      end
   end
   assign tick = (s_q.st == adcc_pkg::ST_CONV) && (s_q.pre == div_m1);
   assign done = tick && (s_q.cyc == 5'h01) && s_q.en;

   // trigger select; free running uses completion, not the flag level
   always_comb begin
      if (s_q.ts == adcc_pkg::TRIG_FREE_RUN) begin
         trig_sel = 1'b0; // RULE18
      end else begin
         trig_sel = trig_flags[s_q.ts]; // RULE16
      end
   end
   // edge against last sampled selection, so a source switch can make one
   assign trig_edge = s_q.ate & s_q.en & ((trig_sel & ~s_q.trig_prev) // RULE6 RULE15 RULE17
      | (done & (s_q.ts == adcc_pkg::TRIG_FREE_RUN))); // RULE25
   assign sw_start = wr && (idx == adcc_pkg::IDX_CTRL_A) && wb[adcc_pkg::A_START] && wb[adcc_pkg::A_ENABLE];
   assign start = (s_q.st == adcc_pkg::ST_IDLE || done) && (sw_start || trig_edge);
   // low byte read in flight; a completion between capture and lock would split the pair
   assign low_hold = psel && !pwrite && mapped && (idx == adcc_pkg::IDX_RESULT_LOW); // RULE12

   // read presentation follows the live alignment bit
   always_comb begin
      if (s_q.align) begin
         high_rd = s_q.result[9:2]; // RULE14 RULE22
         low_rd = {s_q.result[1:0], 6'h00}; // RULE14 RULE24
      end else begin
         high_rd = {6'h00, s_q.result[9:8]}; // RULE14 RULE24
         low_rd = s_q.result[7:0]; // RULE14
      end
      ctrl_a_rd = {s_q.en, (s_q.st == adcc_pkg::ST_CONV), s_q.ate, s_q.flag, s_q.ie, s_q.div}; // RULE5
      case (idx)
         adcc_pkg::IDX_RESULT_LOW: rd_mux = low_rd;
         adcc_pkg::IDX_RESULT_HIGH: rd_mux = high_rd;
         adcc_pkg::IDX_CTRL_A: rd_mux = ctrl_a_rd;
         adcc_pkg::IDX_CTRL_B: rd_mux = {1'b0, s_q.cme, 3'h0, s_q.ts}; // RULE24
         adcc_pkg::IDX_CHAN_REF: rd_mux = {s_q.refsel, s_q.align, s_q.chsel};
         adcc_pkg::IDX_PIN_DISABLE: rd_mux = s_q.didr;
         default: rd_mux = 8'h00;
      endcase
   end

   // next state of the whole block
   always_comb begin
      s_d = s_q;
      s_d.start_p = 1'b0;
      s_d.trig_prev = trig_sel;
      s_d.pin_val = pin_raw & ~s_q.didr; // RULE20
      if (setup && !pwrite) begin
         s_d.rdata = mapped ? rd_mux : 8'h00;
      end
      // register writes
      if (wr) begin
         case (idx)
            adcc_pkg::IDX_CTRL_A: begin
               s_d.en = wb[adcc_pkg::A_ENABLE];
               s_d.ate = wb[adcc_pkg::A_AUTO];
               s_d.ie = wb[adcc_pkg::A_IRQ_EN];
               s_d.div = wb[adcc_pkg::A_DIV_LSB +: 3];
               if (wb[adcc_pkg::A_FLAG]) begin
                  s_d.flag = 1'b0; // RULE9
               end
               if (wb[adcc_pkg::A_ENABLE] && !s_q.en) begin
                  s_d.init_pend = 1'b1; // RULE4
               end
            end
            adcc_pkg::IDX_CTRL_B: begin
               s_d.cme = wb[adcc_pkg::B_CMP_MUX];
               s_d.ts = wb[adcc_pkg::B_TRIG_LSB +: 3]; // RULE24
            end
            adcc_pkg::IDX_CHAN_REF: begin
               s_d.refsel = wb[adcc_pkg::C_REF_LSB +: 2]; // RULE23
               s_d.align = wb[adcc_pkg::C_ALIGN]; // RULE22
               s_d.chsel = wb[adcc_pkg::C_CHAN_LSB +: 5]; // RULE23
            end
            adcc_pkg::IDX_PIN_DISABLE: s_d.didr = wb;
            default: s_d.didr = s_q.didr;
         endcase
      end
      // result lock: low read holds result until high read
      if (rd && idx == adcc_pkg::IDX_RESULT_LOW) begin
         s_d.lock = 1'b1; // RULE12
      end else if (rd && idx == adcc_pkg::IDX_RESULT_HIGH) begin
         s_d.lock = 1'b0; // RULE12
      end
      if (irq_vector_ack) begin
         s_d.flag = 1'b0; // RULE9
      end
      // conversion sequencing
      case (s_q.st)
         adcc_pkg::ST_IDLE: begin
            s_d.pre = 7'h00;
         end
         adcc_pkg::ST_CONV: begin
            s_d.pre = tick ? 7'h00 : 7'(s_q.pre + 7'h01);
            if (tick) begin
               s_d.cyc = 5'(s_q.cyc - 5'h01);
            end
            if (done) begin
               s_d.st = adcc_pkg::ST_IDLE; // RULE5
               s_d.flag = 1'b1; // RULE7
               if (!s_q.lock && !low_hold) begin
                  s_d.result = core_result; // RULE7 RULE12
               end
            end
         end
         default: s_d.st = adcc_pkg::ST_IDLE;
      endcase
      // a new conversion latches channel and reference for its duration
      if (start) begin
         s_d.st = adcc_pkg::ST_CONV; // RULE2 RULE3
         s_d.start_p = 1'b1;
         s_d.pre = 7'h00;
         s_d.conv_first = s_q.init_pend || !s_q.en;
         s_d.cyc = (s_q.init_pend || !s_q.en) ? adcc_pkg::FIRST_CONV_CYCLES // RULE4
            : adcc_pkg::NORMAL_CONV_CYCLES; // RULE4
         s_d.init_pend = 1'b0;
         s_d.conv_ref = s_d.refsel; // RULE23
         s_d.conv_ch = s_d.chsel; // RULE23
      end
      // turning off aborts at once; overrides any start
      if (!s_d.en) begin
         s_d.st = adcc_pkg::ST_IDLE; // RULE1
         s_d.start_p = 1'b0;
         s_d.init_pend = 1'b0;
      end
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs
   assign prdata = {24'h000000, s_q.rdata};
   assign irq_req = s_q.flag & s_q.ie & global_irq_enable; // RULE8
   assign core_req.busy = (s_q.st == adcc_pkg::ST_CONV);
   assign core_req.start = s_q.start_p;
   assign core_req.first = s_q.conv_first;
   assign core_req.tick = tick;
   assign core_req.reference = s_q.conv_ref;
   assign core_req.channel = s_q.conv_ch;
   assign core_req.powered = s_q.en; // RULE1
   assign pins.buffer_off = s_q.didr; // RULE20
   assign pins.value = s_q.pin_val;
   assign comparator_mux_enable = s_q.cme;

   // checks on the block's own behaviour
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_disable_abort;
      $fell(s_q.en) |-> (s_q.st == adcc_pkg::ST_IDLE);
   endproperty
   a_disable_abort: assert property (p_disable_abort) else $error("conversion kept running after disable"); // RULE1

   property p_single_start;
      (sw_start && s_q.st == adcc_pkg::ST_IDLE) |=> (core_req.busy && core_req.start);
   endproperty
   a_single_start: assert property (p_single_start) else $error("start write did not begin a conversion"); // RULE2

   property p_first_length;
      (start && s_q.init_pend && s_d.en) |=> (s_q.cyc == 5'h19 && core_req.first);
   endproperty
   a_first_length: assert property (p_first_length) else $error("first conversion not 25 cycles"); // RULE4

   property p_normal_length;
      (start && !s_q.init_pend && s_q.en && s_d.en) |=> (s_q.cyc == 5'h0D);
   endproperty
   a_normal_length: assert property (p_normal_length) else $error("normal conversion not 13 cycles"); // RULE4

   property p_busy_read;
      (setup && !pwrite && idx == adcc_pkg::IDX_CTRL_A) |=> (prdata[6] == $past(core_req.busy));
   endproperty
   a_busy_read: assert property (p_busy_read) else $error("start bit does not show busy"); // RULE5

   property p_done_flag;
      done && !irq_vector_ack |=> s_q.flag;
   endproperty
   a_done_flag: assert property (p_done_flag) else $error("completion did not set flag"); // RULE7

   property p_irq_raise;
      ($rose(s_q.flag) && s_q.ie && global_irq_enable) |-> irq_req;
   endproperty
   a_irq_raise: assert property (p_irq_raise) else $error("interrupt not raised"); // RULE8

   property p_ack_clear;
      (irq_vector_ack && !done) |=> !s_q.flag;
   endproperty
   a_ack_clear: assert property (p_ack_clear) else $error("vector ack left flag set"); // RULE9

   property p_lock_hold;
      s_q.lock |=> $stable(s_q.result);
   endproperty
   a_lock_hold: assert property (p_lock_hold) else $error("locked result changed"); // RULE12

   property p_free_run;
      (done && s_q.ate && s_q.ts == adcc_pkg::TRIG_FREE_RUN && s_d.en) |=> core_req.busy ##1 core_req.busy;
   endproperty
   a_free_run: assert property (p_free_run) else $error("free running did not restart"); // RULE25

   property p_no_auto;
      (!s_q.ate && s_q.st == adcc_pkg::ST_IDLE && !sw_start) |=> !core_req.start;
   endproperty
   a_no_auto: assert property (p_no_auto) else $error("trigger started conversion without auto"); // RULE15

   property p_pin_gate;
      s_q.didr[0] |=> !pins.value[0];
   endproperty
   a_pin_gate: assert property (p_pin_gate) else $error("disabled pin read nonzero"); // RULE20

   property p_div_two;
      (tick && s_q.div < 3'h2) |-> (s_q.pre == 7'h01);
   endproperty
   a_div_two: assert property (p_div_two) else $error("codes 0 and 1 not divide by 2"); // RULE11

   property p_div_top;
      (tick && s_q.div == 3'h7) |-> (s_q.pre == 7'h7F);
   endproperty
   a_div_top: assert property (p_div_top) else $error("code 7 not divide by 128"); // RULE11

   property p_free_select;
      (s_q.ts == adcc_pkg::TRIG_FREE_RUN && s_q.st == adcc_pkg::ST_IDLE && !sw_start) |=> !core_req.start;
   endproperty
   a_free_select: assert property (p_free_select) else $error("free running select made a trigger"); // RULE18

   property p_auto_edge;
      (s_q.ate && s_q.en && s_d.en && s_q.st == adcc_pkg::ST_IDLE && trig_sel && !s_q.trig_prev)
         |=> core_req.start;
   endproperty
   a_auto_edge: assert property (p_auto_edge) else $error("trigger edge did not start"); // RULE6 RULE17

   property p_zero_start;
      (wr && idx == adcc_pkg::IDX_CTRL_A && !wb[adcc_pkg::A_START] && !s_q.ate
         && s_q.st == adcc_pkg::ST_IDLE) |=> !core_req.busy;
   endproperty
   a_zero_start: assert property (p_zero_start) else $error("zero start write began a conversion"); // RULE5

   property p_conv_latch;
      (core_req.busy && !core_req.start) |-> ($stable(core_req.channel) && $stable(core_req.reference));
   endproperty
   a_conv_latch: assert property (p_conv_latch) else $error("channel or reference moved mid conversion"); // RULE23

   property p_result_update;
      (done && !s_q.lock && !low_hold) |=> (s_q.result == $past(core_result));
   endproperty
   a_result_update: assert property (p_result_update) else $error("completion did not load result"); // RULE7

   property p_ctrl_b_zero;
      (setup && !pwrite && idx == adcc_pkg::IDX_CTRL_B) |=> (prdata[7] == 1'b0 && prdata[5:3] == 3'h0);
   endproperty
   a_ctrl_b_zero: assert property (p_ctrl_b_zero) else $error("control B unused bits not zero"); // RULE24

   property p_right_high;
      (setup && !pwrite && mapped && idx == adcc_pkg::IDX_RESULT_HIGH && !s_q.align)
         |=> (prdata[7:0] == {6'h00, $past(s_q.result[9:8])});
   endproperty
   a_right_high: assert property (p_right_high) else $error("right aligned high byte wrong"); // RULE14

   property p_left_low;
      (setup && !pwrite && mapped && idx == adcc_pkg::IDX_RESULT_LOW && s_q.align)
         |=> (prdata[7:0] == {$past(s_q.result[1:0]), 6'h00});
   endproperty
   a_left_low: assert property (p_left_low) else $error("left aligned low byte wrong"); // RULE14

   property p_align_live;
      (setup && !pwrite && mapped && idx == adcc_pkg::IDX_RESULT_HIGH && s_q.align)
         |=> (prdata[7:0] == $past(s_q.result[9:2]));
   endproperty
   a_align_live: assert property (p_align_live) else $error("left aligned high byte wrong"); // RULE22
endmodule
`default_nettype wire

// ===== adcc_core_model.sv
// analog core stand-in for the converter control block
// assumes the request bundle timing of adcc_top on one clock
`timescale 1ns/1ps
`default_nettype none
module adcc_core_model (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // request in, result out
   input wire adcc_pkg::adcc_core_req_s req,
   output logic [9:0] result,
   // observation for the bench
   output logic [5:0] ticks,
   output logic [15:0] span,
   output logic [7:0] starts
);
   // result is held only while converting; it toggles when idle so a late sample shows
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result <= 10'h155;
         ticks <= 6'h00;
         span <= 16'h0000;
         starts <= 8'h00;
      end else begin
         result <= req.busy ? {3'h5, req.channel, 2'h2} : ~result;
         if (req.start) begin
            ticks <= {5'h00, req.tick};
            span <= 16'h0001;
            starts <= starts + 8'h01;
         end else begin
            ticks <= ticks + {5'h00, req.tick};
            span <= span + {15'h0000, req.busy};
         end
      end
   end
endmodule
`default_nettype wire

// ===== tb_adcc_top.sv
// self-checking bench for the converter control block
// assumes adcc_top and adcc_core_model; APB master tasks on pclk
`timescale 1ns/1ps
`default_nettype none
module tb_adcc_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, gie = 1'b0, ack = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, d;
   logic pready, pslverr, irq_req, cme, err;
   logic [9:0] core_result, r;
   logic [7:1] trig = 7'h00;
   logic [7:0] pin_raw = 8'hA5, starts, s0;
   logic [5:0] ticks;
   logic [15:0] span;
   adcc_pkg::adcc_core_req_s core_req;
   adcc_pkg::adcc_pin_out_s pins;
   int failures = 0, total_checks = 0;
   localparam logic [11:0] RLO = {adcc_pkg::IDX_RESULT_LOW, 2'h0};
   localparam logic [11:0] RHI = {adcc_pkg::IDX_RESULT_HIGH, 2'h0};
   localparam logic [11:0] RA = {adcc_pkg::IDX_CTRL_A, 2'h0};
   localparam logic [11:0] RB = {adcc_pkg::IDX_CTRL_B, 2'h0};
   localparam logic [11:0] RC = {adcc_pkg::IDX_CHAN_REF, 2'h0};
   localparam logic [11:0] RP = {adcc_pkg::IDX_PIN_DISABLE, 2'h0};
   localparam logic [11:0] REGS [6] = '{RLO, RHI, RA, RB, RC, RP};

   always #12.5 pclk = ~pclk;

   adcc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .core_req(core_req), .core_result(core_result), .trig_flags(trig), .global_irq_enable(gie),
      .irq_vector_ack(ack), .irq_req(irq_req), .pin_raw(pin_raw), .pins(pins), .comparator_mux_enable(cme));
   adcc_core_model core (.pclk(pclk), .presetn(presetn), .req(core_req), .result(core_result),
      .ticks(ticks), .span(span), .starts(starts));

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] v);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, v};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      d = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // wait for the end of a conversion, then check length in ticks and pclk cycles
   task automatic fin(input logic [5:0] n, input int dv);
      @(negedge pclk);
      while (core_req.busy === 1'b1) @(negedge pclk);
      chk("ticks", 32'(n), 32'(ticks));
      chk("span", 32'h1, 32'((span >= n * dv) && (span <= n * dv + dv)));
   endtask

   task automatic idle;
      repeat (6) @(negedge pclk);
      chk("idle", 32'h0, 32'(core_req.busy));
   endtask

   function automatic logic [9:0] res(input logic [4:0] ch);
      return {3'h5, ch, 2'h2};
   endfunction

   task automatic close_out;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // watchdog, well beyond the under 5k cycles the tests need
   initial begin
      #1000000;
      failures++;
      close_out;
   end

   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, REGS[i], 8'h00);
         chk("reset", 32'h0, d);
      end
      apb(1'b0, 12'h1F4, 8'h00);
      chk("unmapped", 32'h1, {31'h0, err});
      apb(1'b1, RB, 8'h7F);
      apb(1'b0, RB, 8'h00);
      chk("ctrl_b", 32'h47, d);
      chk("cme", 32'h1, 32'(cme));
      apb(1'b1, RB, 8'h00);
      apb(1'b1, RC, 8'h05);
      apb(1'b1, RA, 8'hC0);
      apb(1'b0, RA, 8'h00);
      chk("busy_bit", 32'hC0, d);
      fin(6'd25, 2);
      apb(1'b0, RA, 8'h00);
      chk("done", 32'h90, d);
      r = res(5'h05);
      apb(1'b0, RLO, 8'h00);
      chk("low", 32'(r[7:0]), d);
      apb(1'b0, RHI, 8'h00);
      chk("high", 32'(r[9:8]), d);
      apb(1'b1, RA, 8'h80);
      apb(1'b0, RA, 8'h00);
      chk("zero_wr", 32'h90, d);
      apb(1'b1, RA, 8'h90);
      apb(1'b0, RA, 8'h00);
      chk("clear", 32'h80, d);
      // every divider code; each start gives exactly one conversion
      for (int c = 0; c < 8; c++) begin
         apb(1'b1, RA, 8'hD0 | 8'(c));
         fin(6'd13, c < 2 ? 2 : 1 << c);
         idle;
      end
      // low read locks the result until high is read
      apb(1'b0, RLO, 8'h00);
      apb(1'b1, RC, 8'h1A);
      apb(1'b1, RA, 8'hD0);
      fin(6'd13, 2);
      apb(1'b0, RHI, 8'h00);
      chk("locked", 32'(r[9:8]), d);
      apb(1'b1, RA, 8'hD0);
      fin(6'd13, 2);
      r = res(5'h1A);
      apb(1'b1, RC, 8'h3A);
      apb(1'b0, RLO, 8'h00);
      chk("left_low", 32'({r[1:0], 6'h0}), d);
      apb(1'b0, RHI, 8'h00);
      chk("left_high", 32'(r[9:2]), d);
      apb(1'b1, RC, 8'h1A);
      apb(1'b0, RLO, 8'h00);
      chk("re_low", 32'(r[7:0]), d);
      apb(1'b0, RHI, 8'h00);
      chk("re_high", 32'(r[9:8]), d);
      // interrupt request and vector acknowledge
      apb(1'b1, RA, 8'h88);
      @(negedge pclk);
      chk("irq_gie_off", 32'h0, 32'(irq_req));
      @(posedge pclk) gie <= 1'b1;
      @(negedge pclk);
      chk("irq_on", 32'h1, 32'(irq_req));
      @(posedge pclk) ack <= 1'b1;
      @(posedge pclk) ack <= 1'b0;
      @(negedge pclk);
      chk("irq_ack", 32'h0, 32'(irq_req));
      // each trigger source, ignored without auto trigger
      for (int s = 1; s < 8; s++) begin
         apb(1'b1, RB, 8'(s));
         apb(1'b1, RA, 8'h90);
         @(posedge pclk) trig[s] <= 1'b1;
         idle;
         @(posedge pclk) trig[s] <= 1'b0;
         apb(1'b1, RA, 8'hB0);
         @(posedge pclk) trig[s] <= 1'b1;
         repeat (4) @(negedge pclk);
         chk("trig", 32'h1, 32'(core_req.busy));
         fin(6'd13, 2);
         @(posedge pclk) trig[s] <= 1'b0;
      end
      apb(1'b1, RB, 8'h01);
      @(posedge pclk) trig[7] <= 1'b1;
      idle;
      apb(1'b1, RB, 8'h07);
      repeat (3) @(negedge pclk);
      chk("switch", 32'h1, 32'(core_req.busy));
      fin(6'd13, 2);
      apb(1'b1, RB, 8'h00);
      idle;
      // free running, then disable mid conversion
      s0 = starts;
      apb(1'b1, RA, 8'hF0);
      repeat (100) @(negedge pclk);
      chk("free_run", 32'h1, 32'((starts - s0) >= 8'h03));
      apb(1'b1, RA, 8'h00);
      repeat (2) @(negedge pclk);
      chk("abort", 32'h0, 32'({core_req.busy, core_req.powered}));
      apb(1'b1, RC, 8'hC5);
      apb(1'b1, RA, 8'hC0);
      apb(1'b1, RC, 8'h00);
      @(negedge pclk);
      chk("first", 32'h1, 32'(core_req.first));
      chk("conv_ref", 32'h3, 32'(core_req.reference));
      chk("conv_ch", 32'h05, 32'(core_req.channel));
      fin(6'd25, 2);
      apb(1'b1, RP, 8'h0F);
      repeat (2) @(negedge pclk);
      chk("pins", 32'hA0, 32'(pins.value));
      chk("buf_off", 32'h0F, 32'(pins.buffer_off));
      close_out;
   end
endmodule
`default_nettype wire
